// ---- src/boot_remap_address_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none

module boot_remap_address_decoder #(
	parameter int unsigned NUM_MASTERS     = boot_remap_pkg::NUM_MASTERS,
	parameter int unsigned NUM_CPU_MASTERS = boot_remap_pkg::NUM_CPU_MASTERS
) (
	// clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        reset_n_i,
	// strap and configuration
	input  wire logic                        boot_select_pin_i,
	input  wire logic                        remap_set_i,
	input  wire logic                        remap_clear_i,
	input  wire logic                        external_select_one_dynamic_i,
	// master requests
	input  wire logic [NUM_MASTERS-1:0]      req_valid_i,
	input  wire logic [NUM_MASTERS*32-1:0]   req_addr_i,
	// routing answers
	output logic [NUM_MASTERS-1:0]           route_valid_o,
	output logic [NUM_MASTERS*4-1:0]         route_target_o,
	output logic [NUM_MASTERS*3-1:0]         route_ext_select_o,
	output logic [NUM_MASTERS-1:0]           route_ext_dynamic_o,
	output logic [NUM_MASTERS-1:0]           route_abort_o,
	// status
	output logic                             remap_o,
	output logic                             boot_select_o,
	output logic                             smc_byte_select_o,
	output logic [1:0]                       smc_bus_width_o,
	output logic                             smc_rw_by_cs_o
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                         strap_taken;
		logic                         boot_sel;
		logic                         remap;
		logic                         dyn_on_one;
		logic [NUM_MASTERS-1:0]       valid;
		logic [NUM_MASTERS*4-1:0]     target;
		logic [NUM_MASTERS*3-1:0]     ext_cs;
		logic [NUM_MASTERS-1:0]       ext_dyn;
		logic [NUM_MASTERS-1:0]       abort;
		logic                         smc_byte_sel;
		logic [1:0]                   smc_width;
		logic                         smc_rw_cs;
	} state_s;

	state_s state_ff;
	state_s nxt_state;

	logic                         boot_sel_now;
	logic [NUM_MASTERS*4-1:0]     dec_target;
	logic [NUM_MASTERS*3-1:0]     dec_ext_cs;
	logic [NUM_MASTERS-1:0]       dec_ext_dyn;
	logic [NUM_MASTERS-1:0]       dec_abort;

	// strap used live on the first cycle, held value afterwards
	assign boot_sel_now = state_ff.strap_taken ? state_ff.boot_sel : boot_select_pin_i;

	////////////////////////////////////////////////////////////////////////////
	// per-master decoders

	for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_master
		boot_remap_decode_if dif ();

		assign dif.cpu_master = (m < NUM_CPU_MASTERS);
		assign dif.remap      = state_ff.remap;
		assign dif.boot_sel   = boot_sel_now;
		assign dif.dyn_on_one = state_ff.dyn_on_one;
		assign dif.addr       = req_addr_i[m*32 +: 32];

		boot_remap_decode u_decode (
			.dec (dif.decoder)
		);

		assign dec_target[m*4 +: 4]  = dif.target;
		assign dec_ext_cs[m*3 +: 3]  = dif.ext_cs;
		assign dec_ext_dyn[m]        = dif.ext_dynamic;
		assign dec_abort[m]          = dif.abort;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_state = state_ff;
		// capture strap once after reset release
		if (!state_ff.strap_taken) begin
			nxt_state.strap_taken = 1'b1;
			nxt_state.boot_sel    = boot_select_pin_i;
			if (!boot_select_pin_i) begin
				nxt_state.smc_byte_sel = boot_remap_pkg::BOOT_BYTE_SELECT;
				nxt_state.smc_width    = boot_remap_pkg::BOOT_BUS_16;
				nxt_state.smc_rw_cs    = boot_remap_pkg::BOOT_RW_BY_CS;
			end
		end
		if (remap_set_i) begin
			nxt_state.remap = 1'b1;
		end else if (remap_clear_i) begin
			nxt_state.remap = 1'b0;
		end
		nxt_state.dyn_on_one = external_select_one_dynamic_i;
		// registered routing answer
		nxt_state.valid   = req_valid_i;
		nxt_state.target  = dec_target;
		nxt_state.ext_cs  = dec_ext_cs;
		nxt_state.ext_dyn = dec_ext_dyn;
		// abort only for a real request
		nxt_state.abort   = dec_abort & req_valid_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			state_ff              <= '0;
			state_ff.remap        <= boot_remap_pkg::RESET_REMAP;
			state_ff.dyn_on_one   <= boot_remap_pkg::RESET_DYN_ON_ONE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign route_valid_o       = state_ff.valid;
	assign route_target_o      = state_ff.target;
	assign route_ext_select_o  = state_ff.ext_cs;
	assign route_ext_dynamic_o = state_ff.ext_dyn;
	assign route_abort_o       = state_ff.abort;
	assign remap_o             = state_ff.remap;
	assign boot_select_o       = state_ff.boot_sel;
	assign smc_byte_select_o   = state_ff.smc_byte_sel;
	assign smc_bus_width_o     = state_ff.smc_width;
	assign smc_rw_by_cs_o      = state_ff.smc_rw_cs;

endmodule : boot_remap_address_decoder

`default_nettype wire

// ---- src/boot_remap_decode.sv ----
`timescale 1ns/100ps
`default_nettype none

module boot_remap_decode (
	boot_remap_decode_if.decoder dec
);

	logic [3:0] bank;
	logic [7:0] area;

	assign bank = dec.addr[boot_remap_pkg::BANK_MSB:boot_remap_pkg::BANK_LSB];
	assign area = dec.addr[boot_remap_pkg::AREA_MSB:boot_remap_pkg::AREA_LSB];

	always_comb begin
		dec.target      = boot_remap_pkg::TGT_NONE;
		dec.ext_cs      = 3'h0;
		dec.ext_dynamic = 1'b0;
		dec.abort       = 1'b0;
		// remap wins over the strap
		if (dec.remap) begin
			dec.boot_map = boot_remap_pkg::BOOT_REMAPPED;
		end else if (dec.boot_sel) begin
			dec.boot_map = boot_remap_pkg::BOOT_INTERNAL;
		end else begin
			dec.boot_map = boot_remap_pkg::BOOT_EXTERNAL;
		end
		if (bank == boot_remap_pkg::BANK_INTERNAL) begin
			if (area == boot_remap_pkg::AREA_BOOT && dec.cpu_master) begin
				case (dec.boot_map)
					boot_remap_pkg::BOOT_INTERNAL: begin
						dec.target = boot_remap_pkg::TGT_ROM;
					end
					boot_remap_pkg::BOOT_EXTERNAL: begin
						dec.target = boot_remap_pkg::TGT_EXT;
					end
					default: begin
						dec.target = boot_remap_pkg::TGT_RAM0;
					end
				endcase
			end else if (area == boot_remap_pkg::AREA_ROM) begin
				dec.target = boot_remap_pkg::TGT_ROM;
			end else if (area == boot_remap_pkg::AREA_RAM0) begin
				dec.target = boot_remap_pkg::TGT_RAM0;
			end else if (area == boot_remap_pkg::AREA_RAM1) begin
				dec.target = boot_remap_pkg::TGT_RAM1;
			end else if (area == boot_remap_pkg::AREA_USBH) begin
				dec.target = boot_remap_pkg::TGT_USBH;
			end else begin
				dec.abort = 1'b1;
			end
		end else if (bank >= boot_remap_pkg::BANK_EXT_FIRST && bank <= boot_remap_pkg::BANK_EXT_LAST) begin
			dec.target = boot_remap_pkg::TGT_EXT;
			// one bank per select
			// bank one carries select zero, so bank two is select one
			dec.ext_cs = bank[2:0] - 3'h1;
			dec.ext_dynamic = dec.dyn_on_one && (bank == 4'h2);
		end else if (bank == boot_remap_pkg::BANK_PERIPH) begin
			dec.target = boot_remap_pkg::TGT_PERIPH;
		end else begin
			dec.abort = 1'b1;
		end
	end

endmodule : boot_remap_decode

`default_nettype wire

// ---- src/boot_remap_decode_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface boot_remap_decode_if;
	logic                        cpu_master;
	logic                        remap;
	logic                        boot_sel;
	logic                        dyn_on_one;
	logic [31:0]                 addr;
	boot_remap_pkg::target_e     target;
	logic [2:0]                  ext_cs;
	logic                        ext_dynamic;
	logic                        abort;
	boot_remap_pkg::boot_map_e   boot_map;

	modport requester (output cpu_master, output remap, output boot_sel, output dyn_on_one, output addr,
	                   input target, input ext_cs, input ext_dynamic, input abort, input boot_map);
	modport decoder   (input cpu_master, input remap, input boot_sel, input dyn_on_one, input addr,
	                   output target, output ext_cs, output ext_dynamic, output abort, output boot_map);
endinterface : boot_remap_decode_if

`default_nettype wire

// ---- src/boot_remap_pkg.sv ----
package boot_remap_pkg;

	// address split
	localparam int unsigned BANK_MSB        = 31;
	localparam int unsigned BANK_LSB        = 28;
	localparam int unsigned AREA_MSB        = 27;
	localparam int unsigned AREA_LSB        = 20;
	localparam int unsigned NUM_MASTERS     = 6;
	localparam int unsigned NUM_CPU_MASTERS = 2;

	// banks
	localparam logic [3:0] BANK_INTERNAL  = 4'h0;
	localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
	localparam logic [3:0] BANK_EXT_LAST  = 4'h7;
	localparam logic [3:0] BANK_PERIPH    = 4'hf;

	// 1-Mbyte areas inside bank zero
	localparam logic [7:0] AREA_BOOT = 8'h00;
	localparam logic [7:0] AREA_ROM  = 8'h01;
	localparam logic [7:0] AREA_RAM0 = 8'h02;
	localparam logic [7:0] AREA_RAM1 = 8'h03;
	localparam logic [7:0] AREA_USBH = 8'h05;

	// reset values
	localparam logic RESET_REMAP       = 1'b0;
	localparam logic RESET_DYN_ON_ONE  = 1'b0;

	// static controller boot defaults for external boot
	localparam logic       BOOT_BYTE_SELECT = 1'b1;
	localparam logic [1:0] BOOT_BUS_16      = 2'h1;
	localparam logic       BOOT_RW_BY_CS    = 1'b1;

	typedef enum logic [3:0] {
		TGT_NONE   = 4'h0,
		TGT_ROM    = 4'h1,
		TGT_RAM0   = 4'h2,
		TGT_RAM1   = 4'h3,
		TGT_USBH   = 4'h4,
		TGT_EXT    = 4'h5,
		TGT_PERIPH = 4'h6
	} target_e;

	typedef enum logic [1:0] {
		BOOT_INTERNAL = 2'h0,
		BOOT_EXTERNAL = 2'h1,
		BOOT_REMAPPED = 2'h2
	} boot_map_e;

endpackage : boot_remap_pkg

// ---- verif/boot_remap_address_decoder_properties.sv ----
`timescale 1ns/100ps
`default_nettype none

module boot_remap_address_decoder_properties #(
	parameter int unsigned NUM_MASTERS = boot_remap_pkg::NUM_MASTERS
) (
	// clock and reset
	input wire logic                     core_clk_i,
	input wire logic                     reset_n_i,
	// inputs
	input wire logic                     remap_set_i,
	input wire logic                     external_select_one_dynamic_i,
	input wire logic [NUM_MASTERS-1:0]   req_valid_i,
	input wire logic [NUM_MASTERS*32-1:0] req_addr_i,
	// outputs
	input wire logic [NUM_MASTERS*4-1:0] route_target_o,
	input wire logic [NUM_MASTERS*3-1:0] route_ext_select_o,
	input wire logic [NUM_MASTERS-1:0]   route_ext_dynamic_o,
	input wire logic [NUM_MASTERS-1:0]   route_abort_o,
	input wire logic                     remap_o,
	input wire logic                     boot_select_o,
	input wire logic                     smc_byte_select_o,
	input wire logic [1:0]               smc_bus_width_o,
	input wire logic                     smc_rw_by_cs_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence area0_s;
		req_valid_i[0] && req_addr_i[31:20] == 12'h000;
	endsequence
	sequence bank_s(logic [3:0] b);
		req_valid_i[0] && req_addr_i[31:28] == b;
	endsequence

	periph_route_a: assert property (
		bank_s(4'hf) |=> route_target_o[3:0] == 4'h6 && !route_abort_o[0]) else $error("periph bank");
	ext_route_a: assert property (
		req_valid_i[0] && !req_addr_i[31] && req_addr_i[30:28] != 3'h0 |=> route_target_o[3:0] == 4'h5
		&& route_ext_select_o[2:0] == $past(req_addr_i[30:28]) - 3'h1) else $error("ext bank");
	unused_abort_a: assert property (
		req_valid_i[0] && req_addr_i[31] && req_addr_i[30:28] != 3'h7 |=> route_abort_o[0]
		&& route_target_o[3:0] == 4'h0) else $error("no abort");
	remap_zero_a: assert property (
		remap_o ##0 area0_s |=> route_target_o[3:0] == 4'h2) else $error("remap zero");
	rom_boot_a: assert property (
		!remap_o && boot_select_o ##0 area0_s |=> route_target_o[3:0] == 4'h1) else $error("rom boot");
	ext_boot_a: assert property (
		$past(reset_n_i) && !remap_o && !boot_select_o ##0 area0_s |=> route_target_o[3:0] == 4'h5
		&& route_ext_select_o[2:0] == 3'h0) else $error("ext boot");
	strap_hold_a: assert property (
		$past(reset_n_i) && $past(reset_n_i, 2) |-> $stable(boot_select_o)) else $error("strap moved");
	smc_default_a: assert property (
		$past(reset_n_i) && $past(reset_n_i, 2) |-> smc_byte_select_o == !boot_select_o
		&& smc_bus_width_o == {1'b0, !boot_select_o} && smc_rw_by_cs_o == !boot_select_o) else $error("smc");
	remap_set_a: assert property (
		remap_set_i |=> remap_o) else $error("remap set");
	dyn_select_a: assert property (
		bank_s(4'h2) ##0 $past(reset_n_i) |=> route_ext_dynamic_o[0] == $past(external_select_one_dynamic_i, 2))
		else $error("dyn");
endmodule : boot_remap_address_decoder_properties

bind boot_remap_address_decoder boot_remap_address_decoder_properties #(.NUM_MASTERS(NUM_MASTERS)) u_props (
	.core_clk_i, .reset_n_i, .remap_set_i, .external_select_one_dynamic_i, .req_valid_i, .req_addr_i,
	.route_target_o, .route_ext_select_o, .route_ext_dynamic_o, .route_abort_o, .remap_o, .boot_select_o,
	.smc_byte_select_o, .smc_bus_width_o, .smc_rw_by_cs_o);

`default_nettype wire

// ---- verif/boot_remap_address_decoder_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); end end

module boot_remap_address_decoder_tb;
	logic core_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic strap = 1'b1;
	logic rm_set = 1'b0;
	logic rm_clr = 1'b0;
	logic dyn = 1'b0;
	logic [5:0] drv_valid = '0;
	logic [191:0] drv_addr = '0;
	logic [5:0] valid, rv, rab, rdy;
	logic [191:0] addr;
	logic [23:0] rt;
	logic [17:0] rx;
	logic remap, bsel, byte_sel, rwcs;
	logic [1:0] width;
	logic exp_rm = 1'b0;
	logic exp_bs = 1'b1;
	int num_errors = 0;
	int tests_run = 0;

	always #5 core_clk_i = ~core_clk_i;

	boot_remap_master_model u_boot_remap_master_model (.clk_i(core_clk_i), .rst_n_i(reset_n_i), .valid_i(drv_valid),
		.addr_i(drv_addr), .valid_o(valid), .addr_o(addr));
	boot_remap_address_decoder u_boot_remap_address_decoder (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.boot_select_pin_i(strap), .remap_set_i(rm_set), .remap_clear_i(rm_clr),
		.external_select_one_dynamic_i(dyn), .req_valid_i(valid), .req_addr_i(addr), .route_valid_o(rv),
		.route_target_o(rt), .route_ext_select_o(rx), .route_ext_dynamic_o(rdy), .route_abort_o(rab),
		.remap_o(remap), .boot_select_o(bsel), .smc_byte_select_o(byte_sel), .smc_bus_width_o(width),
		.smc_rw_by_cs_o(rwcs));

	////////////////////////////////////////////////////////////////////////////////
	// 0 none, 1 rom, 2 sram0, 3 sram1, 4 usb host, 5 external, 6 peripheral
	function automatic logic [3:0] exp_tgt(input int m, input logic [31:0] a);
		if (a[31:28] == 4'hf) return 4'h6;
		if (a[31:28] != 4'h0) return a[31] ? 4'h0 : 4'h5;
		case (a[27:20])
			8'h00: return (m > 1) ? 4'h0 : (exp_rm ? 4'h2 : (exp_bs ? 4'h1 : 4'h5));
			8'h01: return 4'h1;
			8'h02: return 4'h2;
			8'h03: return 4'h3;
			8'h05: return 4'h4;
			default: return 4'h0;
		endcase
	endfunction : exp_tgt

	task automatic ask(input int m, input logic [31:0] a);
		logic [3:0] t;
		t = exp_tgt(m, a);
		drv_valid = 6'h01 << m;
		drv_addr[m*32+:32] = a;
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK(rv, drv_valid)
		`CHK(rt[m*4+:4], t)
		`CHK(rab[m], t == 4'h0)
		`CHK(rx[m*3+:3], (t == 4'h5 && a[31:28] != 4'h0) ? a[30:28] - 3'h1 : 3'h0)
		`CHK(rdy[m], dyn && a[31:28] == 4'h2)
	endtask : ask

	task automatic rst(input logic bs);
		reset_n_i = 1'b0;
		strap = bs;
		repeat (4) @(posedge core_clk_i);
		#1;
		`CHK(rv, 6'h00)
		reset_n_i = 1'b1;
		exp_bs = bs;
		exp_rm = 1'b0;
		ask(0, 32'h0);
		`CHK(bsel, bs)
		`CHK(remap, 1'b0)
		`CHK({byte_sel, width, rwcs}, bs ? 4'h0 : 4'hb)
	endtask : rst

	task automatic strap_late;
		strap = ~exp_bs;
		ask(1, 32'h0);
	endtask : strap_late

	task automatic map_all;
		for (int m = 0; m < 6; m++) begin
			for (int b = 0; b < 16; b++) ask(m, {b[3:0], 28'h0123456});
			for (int i = 0; i < 8; i++) ask(m, {4'h0, (i == 7) ? 8'hff : i[7:0], 20'hffffc});
		end
	endtask : map_all

	task automatic dyn_sel;
		dyn = 1'b1;
		ask(0, 32'h2000_0000);
		ask(3, 32'h2abc_0000);
		ask(0, 32'h3000_0000);
		dyn = 1'b0;
		ask(0, 32'h2000_0000);
	endtask : dyn_sel

	task automatic remap_seq;
		// software moves sram0 only once booted
		rm_set = 1'b1;
		@(posedge core_clk_i);
		#1;
		rm_set = 1'b0;
		exp_rm = 1'b1;
		`CHK(remap, 1'b1)
		ask(0, 32'h0);
		ask(1, 32'h000f_fffc);
		ask(2, 32'h0);
		ask(0, 32'h0010_0000);
		rm_set = 1'b1;
		rm_clr = 1'b1;
		@(posedge core_clk_i);
		#1;
		rm_set = 1'b0;
		`CHK(remap, 1'b1)
		@(posedge core_clk_i);
		#1;
		rm_clr = 1'b0;
		exp_rm = 1'b0;
		`CHK(remap, 1'b0)
		ask(0, 32'h0);
	endtask : remap_seq

	task automatic end_sim;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	initial begin
		#50000;
		num_errors++;
		end_sim();
	end

	initial begin
		@(posedge core_clk_i);
		#1;
		rst(1'b1);
		strap_late();
		map_all();
		dyn_sel();
		remap_seq();
		rst(1'b0);
		strap_late();
		map_all();
		end_sim();
	end
endmodule : boot_remap_address_decoder_tb

`default_nettype wire

// ---- verif/boot_remap_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module boot_remap_master_model #(
	parameter int unsigned NUM = 6
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [NUM-1:0]    valid_i,
	input  wire logic [NUM*32-1:0] addr_i,
	output var  logic [NUM-1:0]    valid_o,
	output var  logic [NUM*32-1:0] addr_o
);
	// idle masters toggle address so stale values never pass
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			valid_o <= '0;
			addr_o  <= '0;
		end else begin
			valid_o <= valid_i;
			for (int m = 0; m < NUM; m++) begin
				addr_o[m*32+:32] <= valid_i[m] ? addr_i[m*32+:32] : ~addr_o[m*32+:32];
			end
		end
	end
endmodule : boot_remap_master_model

`default_nettype wire
